// File: rtl/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADR_CTRL0 8'h00
`define SSP_ADR_CTRL1 8'h04
`define SSP_ADR_DATA 8'h08
`define SSP_ADR_STAT 8'h0C
`define SSP_ADR_PSC 8'h10
`define SSP_ADR_MASK 8'h14
`define SSP_ADR_RAW 8'h18
`define SSP_ADR_MSKD 8'h1C
`define SSP_ADR_ICLR 8'h20
`define SSP_ADR_DMA 8'h24
`define SSP_BIT_OVR 0
`define SSP_BIT_TMO 1
`define SSP_BIT_RXL 2
`define SSP_BIT_TXL 3
`define SSP_BIT_RXDMA 0
`define SSP_BIT_TXDMA 1
`define SSP_BIT_EN 1
`define SSP_BIT_SLAVE 2
`define SSP_CR0_SIZE_RST 4'h7
`define SSP_PSC_RST 8'h02
`define SSP_LEVEL_MARK 4'h4
`define SSP_TMO_BITS 6'h20
`endif

// File: rtl/ssp_pkg.sv
`default_nettype none
package ssp_pkg;
  typedef enum logic [0:0] {SSP_IDLE, SSP_SHIFT} ssp_state_e;
  typedef logic [15:0] ssp_word_t;
endpackage
`default_nettype wire

// File: rtl/ssp_core.sv
// How it works
// - Writing one to bit 1 clears time-out
// - Writing one to bit 0 clears overrun
// - DMA enables: tx bit 1, rx bit 0
// - Transmit FIFO, eight 16-bit words
// - Receive FIFO, eight 16-bit words
// - Shift out on data-out, in on data-in
// - Master clock from two chained free counters
// - First stage divides by even 2..254
// - Second stage divides by rate plus one
// - Tx level set at four or fewer
// - Tx level also set while disabled
// - Rx level set at four or more
// - Time-out after 32 idle bits, data waiting
// - Time-out same in master and slave
// - Transfer start clears time-out if space
// - Start when full keeps time-out; overrun if still full at word end
// - Overrun when writing into full rx FIFO
// - Sources masked, ORed onto one output
// - Four-bit mask register, reset zero
// - Raw and masked flags both readable
// - Word arriving when full is discarded
// - DMA requests at half level, held until clear
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"

module ssp_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic pop_i,
  output logic [W-1:0] rdata_o,
  output logic [AW:0] count_o,
  output logic full_o,
  output logic empty_o
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire do_push = push_i & ~full_o;
  wire do_pop = pop_i & ~empty_o;
  assign full_o = (cnt_ff == (AW+1)'(D));
  assign empty_o = (cnt_ff == '0);
  assign count_o = cnt_ff;
  assign rdata_o = mem[rp_ff];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wp_ff] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) begin
        wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
      end
      if (do_pop) begin
        rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

module ssp_core
  import ssp_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_bit_clock_i,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe_n_o,
  input wire logic frame_i,
  output logic frame_n_o,
  output logic frame_oe_n_o,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_n_o,
  output logic combined_irq_o,
  output logic tx_dma_req_o,
  output logic rx_dma_req_o,
  input wire logic tx_dma_clr_i,
  input wire logic rx_dma_clr_i
);
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [3:0] size_ff;
  logic [7:0] rate_ff;
  logic [6:0] psc_ff;
  logic [2:0] cr1_ff;
  logic [3:0] mask_ff;
  logic [1:0] dma_ff;
  logic tmo_ff;
  logic ovr_ff;
  logic [5:0] idle_cnt_ff;
  logic [6:0] div1_ff;
  logic [7:0] div2_ff;
  logic half_ff;
  ssp_state_e state_ff;
  logic sclk_ff;
  logic sclk_prev_ff;
  logic frame_ff;
  ssp_word_t tsh_ff;
  ssp_word_t rsh_ff;
  logic [4:0] bits_ff;
  logic txreq_ff;
  logic rxreq_ff;

  // Bus: one wait state, the access acts on the acking edge
  wire req = wb_cyc_i & wb_stb_i;
  wire act = req & ack_ff;
  wire wr = act & wb_we_i & wb_sel_i[0];
  wire rd = act & ~wb_we_i;
  wire sel_c0 = wb_adr_i == `SSP_ADR_CTRL0;
  wire sel_c1 = wb_adr_i == `SSP_ADR_CTRL1;
  wire sel_dat = wb_adr_i == `SSP_ADR_DATA;
  wire sel_psc = wb_adr_i == `SSP_ADR_PSC;
  wire sel_msk = wb_adr_i == `SSP_ADR_MASK;
  wire sel_icl = wb_adr_i == `SSP_ADR_ICLR;
  wire sel_dma = wb_adr_i == `SSP_ADR_DMA;
  wire port_enable = cr1_ff[`SSP_BIT_EN];
  wire slave = cr1_ff[`SSP_BIT_SLAVE];

  // FIFOs
  wire tx_push = wr & sel_dat & wb_sel_i[1];
  wire rx_pop = rd & sel_dat;
  logic tx_pop;
  logic rx_push;
  ssp_word_t tx_head;
  ssp_word_t rx_head;
  logic [AW:0] tx_cnt;
  logic [AW:0] rx_cnt;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;

  ssp_fifo #(.W(16), .D(DEPTH), .AW(AW)) u_txf (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(tx_push), .wdata_i(wb_dat_i[15:0]),
    .pop_i(tx_pop), .rdata_o(tx_head), .count_o(tx_cnt), .full_o(tx_full),
    .empty_o(tx_empty));

  ssp_fifo #(.W(16), .D(DEPTH), .AW(AW)) u_rxf (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(rx_push), .wdata_i(rsh_ff),
    .pop_i(rx_pop), .rdata_o(rx_head), .count_o(rx_cnt), .full_o(rx_full),
    .empty_o(rx_empty));

  // Prescaler: stage one ticks every divisor/2, stage two every rate+1
  // ticks; each stage-two tick is a half bit period
  wire [6:0] half_div = (psc_ff == 7'h00) ? 7'h01 : psc_ff;
  wire div1_tick = (div1_ff == half_div - 7'h01);
  wire half_tick = div1_tick & (div2_ff == rate_ff);
  wire bit_tick = half_tick & half_ff;

  // Serial engine edges
  wire m_rise = half_tick & ~sclk_ff;
  wire m_fall = half_tick & sclk_ff;
  wire s_rise = serial_bit_clock_i & ~sclk_prev_ff;
  wire s_fall = ~serial_bit_clock_i & sclk_prev_ff;
  wire rise_ev = slave ? s_rise : m_rise;
  wire fall_ev = slave ? s_fall : m_fall;
  wire [4:0] nbits = {1'b0, size_ff} + 5'h01;
  wire last_bit = (bits_ff == nbits);
  wire in_shift = (state_ff == SSP_SHIFT);
  wire m_start = ~slave & ~tx_empty & half_tick & ~half_ff;
  wire s_start = slave & ~frame_i;
  wire start = port_enable & ~in_shift & (m_start | s_start);
  wire s_abort = slave & frame_i & in_shift;
  wire done = in_shift & fall_ev & last_bit;
  assign tx_pop = start & ~tx_empty;
  // Fullness judged at the word's end, so a read during reception saves it
  assign rx_push = done;
  wire overrun_ev = done & rx_full;

  // Interrupt sources
  wire tx_level = (tx_cnt <= (AW+1)'(`SSP_LEVEL_MARK)) | ~port_enable;
  wire rx_level = (rx_cnt >= (AW+1)'(`SSP_LEVEL_MARK));
  wire tmo_ev = ~rx_empty & ~in_shift & bit_tick
    & (idle_cnt_ff == `SSP_TMO_BITS - 6'h01);
  wire [3:0] raw = {tx_level, rx_level, tmo_ff, ovr_ff};
  wire [3:0] masked = raw & mask_ff;
  wire tmo_clr = (wr & sel_icl & wb_dat_i[`SSP_BIT_TMO])
    | (start & ~rx_full);
  wire ovr_clr = wr & sel_icl & wb_dat_i[`SSP_BIT_OVR];
  wire [7:0] stat = {3'h0, in_shift, rx_full, ~rx_empty, ~tx_full, tx_empty};

  // DMA request conditions, four-word bursts
  wire tx_dma_on = port_enable & dma_ff[`SSP_BIT_TXDMA];
  wire rx_dma_on = port_enable & dma_ff[`SSP_BIT_RXDMA];
  wire tx_dma_cond = (tx_cnt <= (AW+1)'(DEPTH) - (AW+1)'(`SSP_LEVEL_MARK));
  wire rx_dma_cond = (rx_cnt >= (AW+1)'(`SSP_LEVEL_MARK));

  logic [31:0] nxt_rdat;
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (wb_adr_i)
      `SSP_ADR_CTRL0: nxt_rdat = {16'h0000, rate_ff, 4'h0, size_ff};
      `SSP_ADR_CTRL1: nxt_rdat = {29'h0, cr1_ff};
      `SSP_ADR_DATA: nxt_rdat = {16'h0000, rx_head};
      `SSP_ADR_STAT: nxt_rdat = {24'h0, stat};
      `SSP_ADR_PSC: nxt_rdat = {24'h0, psc_ff, 1'b0};
      `SSP_ADR_MASK: nxt_rdat = {28'h0, mask_ff};
      `SSP_ADR_RAW: nxt_rdat = {28'h0, raw};
      `SSP_ADR_MSKD: nxt_rdat = {28'h0, masked};
      `SSP_ADR_DMA: nxt_rdat = {30'h0, dma_ff};
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      rdat_ff <= nxt_rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      size_ff <= `SSP_CR0_SIZE_RST;
      rate_ff <= 8'h00;
      cr1_ff <= 3'h0;
      psc_ff <= 7'h01;
      mask_ff <= 4'h0;
      dma_ff <= 2'h0;
    end else if (wr) begin
      if (sel_c0) begin
        size_ff <= (wb_dat_i[3:0] < 4'h3) ? 4'h3 : wb_dat_i[3:0];
      end
      if (sel_c0 & wb_sel_i[1]) begin
        rate_ff <= wb_dat_i[15:8];
      end
      if (sel_c1) begin
        cr1_ff <= wb_dat_i[2:0];
      end
      // Low divisor bit is dropped, so odd factors cannot be set
      if (sel_psc) begin
        psc_ff <= wb_dat_i[7:1];
      end
      if (sel_msk) begin
        mask_ff <= wb_dat_i[3:0];
      end
      if (sel_dma) begin
        dma_ff <= wb_dat_i[1:0];
      end
    end
  end

  // Sticky flags; a raising event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      tmo_ff <= tmo_ev | (tmo_ff & ~tmo_clr);
      ovr_ff <= overrun_ev | (ovr_ff & ~ovr_clr);
    end
  end

  // Idle timer counts whole bit periods; a transfer, an rx FIFO read or an empty rx FIFO restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_ff <= 6'h00;
    end else if (in_shift | rx_empty | rx_pop | start) begin
      idle_cnt_ff <= 6'h00;
    end else if (bit_tick & (idle_cnt_ff != `SSP_TMO_BITS - 6'h01)) begin
      idle_cnt_ff <= idle_cnt_ff + 6'h01;
    end
  end

  // Free-running prescaler counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div1_ff <= 7'h00;
      div2_ff <= 8'h00;
      half_ff <= 1'b0;
    end else begin
      div1_ff <= div1_tick ? 7'h00 : div1_ff + 7'h01;
      if (div1_tick) begin
        div2_ff <= (div2_ff == rate_ff) ? 8'h00 : div2_ff + 8'h01;
      end
      if (half_tick) begin
        half_ff <= ~half_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SSP_IDLE;
      sclk_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      frame_ff <= 1'b1;
      tsh_ff <= 16'h0000;
      rsh_ff <= 16'h0000;
      bits_ff <= 5'h00;
    end else begin
      sclk_prev_ff <= serial_bit_clock_i;
      case (state_ff)
        SSP_IDLE: begin
          sclk_ff <= 1'b0;
          frame_ff <= 1'b1;
          if (start) begin
            state_ff <= SSP_SHIFT;
            frame_ff <= 1'b0;
            bits_ff <= 5'h00;
            rsh_ff <= 16'h0000;
            // An empty slave FIFO sends zeros
            tsh_ff <= tx_empty ? 16'h0000 : tx_head << (5'h10 - nbits);
          end
        end
        SSP_SHIFT: begin
          if (s_abort | done | ~port_enable) begin
            state_ff <= SSP_IDLE;
            sclk_ff <= 1'b0;
            frame_ff <= 1'b1;
          end else if (rise_ev) begin
            sclk_ff <= ~slave;
            rsh_ff <= {rsh_ff[14:0], serial_data_in_i};
            bits_ff <= bits_ff + 5'h01;
          end else if (fall_ev) begin
            sclk_ff <= 1'b0;
            tsh_ff <= {tsh_ff[14:0], 1'b0};
          end
        end
        default: state_ff <= SSP_IDLE;
      endcase
    end
  end

  // DMA requests hold until cleared; disabling drops them at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txreq_ff <= 1'b0;
      rxreq_ff <= 1'b0;
    end else begin
      txreq_ff <= tx_dma_on & ~tx_dma_clr_i & (txreq_ff | tx_dma_cond);
      rxreq_ff <= rx_dma_on & ~rx_dma_clr_i & (rxreq_ff | rx_dma_cond);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign combined_irq_o = |masked;
  assign tx_dma_req_o = txreq_ff;
  assign rx_dma_req_o = rxreq_ff;
  assign serial_bit_clock_o = sclk_ff;
  assign serial_bit_clock_oe_n_o = slave | ~port_enable;
  assign frame_n_o = frame_ff;
  assign frame_oe_n_o = slave | ~port_enable;
  assign serial_data_out_o = tsh_ff[15];
  assign serial_data_out_oe_n_o = ~in_shift;
endmodule

`default_nettype wire

// File: dv/ssp_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_core_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic serial_bit_clock_o,
  input wire logic frame_n_o,
  input wire logic combined_irq_o,
  input wire logic tx_dma_req_o,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_clr_i,
  input wire logic rx_dma_clr_i
);
  logic [3:0] mask_ff;
  logic [1:0] dma_ff;
  logic [7:0] psc_ff;
  logic [7:0] rate_ff;
  logic [15:0] cnt_ff;
  logic [15:0] half_w;
  logic en_ff, sk_ff, seen_ff, wr_w, tick_w, txon_w, rxon_w;
  assign wr_w = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign tick_w = serial_bit_clock_o != sk_ff;
  assign txon_w = dma_ff[1] && en_ff;
  assign rxon_w = dma_ff[0] && en_ff;
  assign half_w = 16'((17'(psc_ff) * (17'(rate_ff) + 17'h1)) >> 1);
  // Shadow copies of the mask, DMA, enable, prescale and rate fields, updated at the ack edge like the design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= 4'h0;
      dma_ff <= 2'h0;
      en_ff <= 1'b0;
      psc_ff <= 8'h02;
      rate_ff <= 8'h00;
    end else if (wr_w) begin
      case (wb_adr_i)
        `SSP_ADR_MASK: mask_ff <= wb_dat_i[3:0];
        `SSP_ADR_DMA: dma_ff <= wb_dat_i[1:0];
        `SSP_ADR_CTRL1: en_ff <= wb_dat_i[`SSP_BIT_EN];
        `SSP_ADR_PSC: psc_ff <= (wb_dat_i[7:1] == 7'h00) ? 8'h02 : {wb_dat_i[7:1], 1'b0};
        `SSP_ADR_CTRL0: rate_ff <= wb_sel_i[1] ? wb_dat_i[15:8] : rate_ff;
        default: ;
      endcase
    end
  end
  // First toggle of a frame is skipped: its phase to the frame start is not fixed
  always_ff @(posedge clk_i) begin
    sk_ff <= serial_bit_clock_o;
    cnt_ff <= tick_w ? 16'h0000 : cnt_ff + 16'h0001;
    seen_ff <= !frame_n_o && (tick_w || seen_ff);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack unasked");
  chk_irq_masked: assert property (mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !combined_irq_o)
    else $error("irq while masked");
  chk_tx_dma_off: assert property (!txon_w && !$past(txon_w) |-> !tx_dma_req_o)
    else $error("tx dma req while off");
  chk_rx_dma_off: assert property (!rxon_w && !$past(rxon_w) |-> !rx_dma_req_o)
    else $error("rx dma req while off");
  chk_dma_clear: assert property ((tx_dma_clr_i && rx_dma_clr_i) [*2] |-> !tx_dma_req_o && !rx_dma_req_o)
    else $error("dma req during clear");
  chk_sclk_frame: assert property ($rose(serial_bit_clock_o) |-> !frame_n_o)
    else $error("clock edge outside frame");
  chk_sclk_half: assert property (tick_w && seen_ff && !frame_n_o |-> cnt_ff == half_w - 16'h1)
    else $error("half period wrong");
endmodule
bind ssp_core ssp_core_chk chk_u (.*);
`default_nettype wire

// File: dv/ssp_periph.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_periph #(
  parameter logic [15:0] INIT = 16'h5A3C
) (
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic sdo_i,
  output logic sdi_o
);
  logic [15:0] cap_ff = INIT;
  logic [15:0] out_ff = 16'h0000;
  logic sdi_ff = 1'b0;
  logic fr_q = 1'b1;
  logic sck_q = 1'b0;
  assign sdi_o = sdi_ff;
  // Echoes the previous frame's word, so each reply is known to the bench;
  // one process keeps every variable single-driven
  always @(frame_n_i or sclk_i) begin
    if (!frame_n_i && fr_q) begin
      out_ff = cap_ff;
      sdi_ff = cap_ff[15];
    end else if (!frame_n_i && sclk_i && !sck_q) begin
      cap_ff = {cap_ff[14:0], sdo_i};
    end else if (!frame_n_i && !sclk_i && sck_q) begin
      out_ff = out_ff << 1;
      sdi_ff = out_ff[15];
    end else if (frame_n_i && !fr_q) begin
      // Released line: show the inverse so a stale level is never mistaken for data
      sdi_ff = ~sdi_ff;
    end
    fr_q = frame_n_i;
    sck_q = sclk_i;
  end
endmodule
`default_nettype wire

// File: dv/sync_serial_port_fifo_irq_clocking_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
module sync_serial_port_fifo_irq_clocking_tb import ssp_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, txc = 1'b0, rxc = 1'b0;
  logic sck_s = 1'b0, fs_n = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, seed = 32'h692E1359;
  wire [31:0] dat_o;
  wire ack, sclk, fr, sdi, sdo, irq, txr, rxr, sck_oe, fr_oe, sdo_oe;
  ssp_word_t rxq[$];
  ssp_word_t prev = 16'h5A3C;
  ssp_word_t sbits;
  int mismatches = 0, checked = 0;
  ssp_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .serial_bit_clock_i(sck_s), .serial_bit_clock_o(sclk), .serial_bit_clock_oe_n_o(sck_oe),
    .frame_i(fs_n), .frame_n_o(fr), .frame_oe_n_o(fr_oe), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .serial_data_out_oe_n_o(sdo_oe), .combined_irq_o(irq),
    .tx_dma_req_o(txr), .rx_dma_req_o(rxr), .tx_dma_clr_i(txc), .rx_dma_clr_i(rxc));
  ssp_periph #(.INIT(16'h5A3C)) peer_u (.sclk_i(sclk), .frame_n_i(fr), .sdo_i(sdo), .sdi_o(sdi));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i);
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), rd, e);
  endtask
  task automatic push();
    seed = lfsr(seed);
    wb(1'b1, `SSP_ADR_DATA, {16'h0000, seed[15:0]});
    if (rxq.size() < 8)
      rxq.push_back(prev);
    prev = seed[15:0];
  endtask
  task automatic idle();
    do wb(1'b0, `SSP_ADR_STAT, 32'h0);
    while (rd[0] !== 1'b1 || rd[4] !== 1'b0);
  endtask
  task automatic pull();
    wb(1'b0, `SSP_ADR_DATA, 32'h0);
    cmp("rx word", rd, {16'h0000, rxq.pop_front()});
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`SSP_ADR_RAW, 32'h8);
    rdc(`SSP_ADR_MASK, 32'h0);
    rdc(`SSP_ADR_DMA, 32'h0);
    cmp("oe idle", {sck_oe, fr_oe, sdo_oe}, 32'h7);
    rdc(8'hFC, 32'h0);
    wb(1'b1, `SSP_ADR_DMA, 32'h3);
    rdc(`SSP_ADR_DMA, 32'h3);
    wb(1'b1, `SSP_ADR_DMA, 32'h0);
    wb(1'b1, `SSP_ADR_PSC, 32'h3);
    rdc(`SSP_ADR_PSC, 32'h2);
    wb(1'b1, `SSP_ADR_CTRL0, 32'h10F);
    repeat (8) push();
    rdc(`SSP_ADR_RAW, 32'h8);
    wb(1'b1, `SSP_ADR_CTRL1, 32'h2);
    rdc(`SSP_ADR_RAW, 32'h0);
    cmp("oe master", {sck_oe, fr_oe}, 32'h0);
    push();
    idle();
    wb(1'b1, `SSP_ADR_DMA, 32'h3);
    rdc(`SSP_ADR_RAW, 32'hD);
    cmp("dma req", {txr, rxr}, 32'h3);
    txc <= 1'b1;
    rxc <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp("dma req clr", {txr, rxr}, 32'h0);
    txc <= 1'b0;
    rxc <= 1'b0;
    wb(1'b1, `SSP_ADR_DMA, 32'h0);
    wb(1'b1, `SSP_ADR_MASK, 32'hF);
    rdc(`SSP_ADR_MSKD, 32'hD);
    cmp("irq", irq, 32'h1);
    // Bit period is 4 clocks here, so 32 periods is 128 clocks
    repeat (140) @(posedge clk_i);
    rdc(`SSP_ADR_RAW, 32'hF);
    wb(1'b1, `SSP_ADR_ICLR, 32'h0);
    rdc(`SSP_ADR_RAW, 32'hF);
    wb(1'b1, `SSP_ADR_ICLR, 32'h1);
    rdc(`SSP_ADR_RAW, 32'hE);
    push();
    idle();
    rdc(`SSP_ADR_RAW, 32'hF);
    wb(1'b1, `SSP_ADR_ICLR, 32'h3);
    rdc(`SSP_ADR_RAW, 32'hC);
    repeat (7) pull();
    repeat (140) @(posedge clk_i);
    rdc(`SSP_ADR_RAW, 32'hA);
    push();
    idle();
    rdc(`SSP_ADR_RAW, 32'h8);
    // Slave mode: bench drives clock and frame; the peer, seeing no clock, holds its line
    wb(1'b1, `SSP_ADR_CTRL1, 32'h6);
    seed = lfsr(seed);
    wb(1'b1, `SSP_ADR_DATA, {16'h0000, seed[15:0]});
    cmp("oe slave", {sck_oe, fr_oe}, 32'h3);
    @(posedge clk_i);
    fs_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      sbits = {sbits[14:0], sdo};
      cmp("slave oe", sdo_oe, 32'h0);
      sck_s <= 1'b1;
      repeat (2) @(posedge clk_i);
      sck_s <= 1'b0;
      @(posedge clk_i);
      fs_n <= (i == 15);
      @(posedge clk_i);
    end
    cmp("slave tx word", sbits, {16'h0000, seed[15:0]});
    rxq.push_back({16{prev[15]}});
    repeat (140) @(posedge clk_i);
    rdc(`SSP_ADR_RAW, 32'hA);
    while (rxq.size() > 0) pull();
    results();
  end
endmodule
`default_nettype wire
